// file: hw/sadc_pkg.sv
// Purpose: Shared constants and types for the converter sequencer.
// Assumes: One 20 MHz system clock; conversion clock arrives as a plain input.
// Notes: Timing of a frame is counted in half periods of the conversion clock.
package sadc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int unsigned SADC_RES_W = 12;
   localparam int unsigned SADC_CHAN_W = 3;
   localparam int unsigned SADC_HALF_W = 5;
   localparam int unsigned SADC_IDX_W = 4;

   // Frame budget, in conversion clock cycles and in half periods
   localparam int unsigned SADC_FRAME_CLKS = 16;
   localparam int unsigned SADC_ACQ_HALVES = 5;    // 2.5 cycles
   localparam int unsigned SADC_DEC_HALVES = 27;   // 13.5 cycles
   localparam logic [SADC_HALF_W-1:0] SADC_HALVES_STD = 5'h02;
   localparam logic [SADC_HALF_W-1:0] SADC_HALVES_BIT5 = 5'h04;
   localparam logic [SADC_HALF_W-1:0] SADC_HALVES_LSB = 5'h03;
   localparam logic [SADC_HALF_W-1:0] SADC_ACQ_LAST = 5'h04;
   localparam logic [SADC_IDX_W-1:0] SADC_IDX_MSB = 4'hb;
   localparam logic [SADC_IDX_W-1:0] SADC_IDX_BIT5 = 4'h5;
   localparam logic [SADC_IDX_W-1:0] SADC_IDX_LSB = 4'h0;

   // Reset values and the starting trial code
   localparam logic [SADC_RES_W-1:0] SADC_RESULT_RST = 12'h000;
   localparam logic [SADC_RES_W-1:0] SADC_CODE_MSB = 12'h800;
   localparam logic [SADC_CHAN_W-1:0] SADC_CHAN_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      SADC_PWR_NONE = 2'b00,
      SADC_PWR_NAP = 2'b01,
      SADC_PWR_SLEEP = 2'b10
   } sadc_pwr_t;

   typedef enum logic [1:0] {
      SADC_ST_IDLE = 2'b00,
      SADC_ST_ARMED = 2'b01,
      SADC_ST_ACQ = 2'b10,
      SADC_ST_CONV = 2'b11
   } sadc_state_t;

   // Host-side strobes and address as one bundle
   typedef struct packed {
      logic cs_n;
      logic wr_n;
      logic rd_n;
      logic chan_addr_bit_hi;
      logic chan_addr_bit_mid;
      logic chan_addr_bit_lo;
   } sadc_host_t;

   // Controls toward the analog front end
   typedef struct packed {
      logic sample_en;
      logic [SADC_CHAN_W-1:0] chan_sel;
      logic [SADC_RES_W-1:0] trial_code;
   } sadc_afe_t;

endpackage

// file: hw/sadc_sar_core.sv
// Purpose: Successive-approximation register with trial code output.
// Assumes: Comparator high means the held input is at or above the trial code.
// Notes: Decisions arrive as one-cycle pulses, MSB first.
`timescale 1ns/100ps
`default_nettype none
module sadc_sar_core #(
   parameter int unsigned RES_W = sadc_pkg::SADC_RES_W
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic i_decide,
   input wire logic [sadc_pkg::SADC_IDX_W-1:0] i_bit_idx,
   input wire logic i_cmp,
   output logic [RES_W-1:0] o_code
);
   import sadc_pkg::*;

   logic [RES_W-1:0] code_ff;
   logic [RES_W-1:0] nxt_code;

   ////////////////////////////////////////////////////////////////////////////
   // Keep or drop the bit under test, then raise the next one
   always_comb begin
      nxt_code = code_ff;
      if (i_load) begin
         nxt_code = RES_W'(SADC_CODE_MSB);
      end else if (i_decide) begin
         nxt_code[i_bit_idx] = i_cmp;
         if (i_bit_idx != SADC_IDX_LSB) begin
            nxt_code[i_bit_idx - 4'h1] = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         code_ff <= RES_W'(SADC_RESULT_RST);
      end else begin
         code_ff <= nxt_code;
      end
   end

   assign o_code = code_ff;

endmodule
`default_nettype wire

// file: hw/sadc_seq.sv
// Purpose: Conversion sequencer of an 8-channel 12-bit SAR converter.
// Assumes: Host strobes and the conversion clock are synchronous to i_clk,
//    which runs well above the conversion clock so every edge is seen.
// Notes: Busy is active low; the result bus is a tristate group (data, enable).
`timescale 1ns/100ps
`default_nettype none
// How it works
// R01 - The three address bits form a binary channel index, the top bit picking the upper four.
// R02 - The host supplies a conversion clock between 200kHz and 8MHz.
// R03 - A conversion starts when the write strobe falls with chip select low and address valid.
// R04 - The frame begins on the first conversion clock rise after that falling strobe.
// R05 - Bit decisions take 13.5 clocks: 1.5 for the LSB, 2 for bit 5, one for each other bit.
// R06 - Each frame opens with 2.5 clocks of acquisition on the selected input.
// R07 - Busy falls just after the start, stays low through the frame, rises once it is done.
// R08 - The 12-bit result is valid on the result bus when busy rises.
// R09 - The selected input is sampled at the start and all inputs are cut off while converting.
// R10 - The host should read each result right after the conversion ends.
// R11 - Acquisition plus decisions fill sixteen conversion clocks per frame.
// R12 - The host should not start again until busy has returned high.
// R13 - With chip select and read both low the result bus is driven.
// R14 - Results are straight binary, zero to all ones at full scale.
// R15 - A read strobe rise picks normal, nap (low address bit) or sleep (middle bit).
// R16 - Starting a conversion ends any power-down state.
module sadc_seq #(
   parameter int unsigned RES_W = sadc_pkg::SADC_RES_W
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire sadc_pkg::sadc_host_t i_host,
   input wire logic i_conv_clk,
   input wire logic i_cmp,
   output logic o_busy_n,
   output logic [RES_W-1:0] o_result_bus,
   output logic o_result_bus_oe,
   output sadc_pkg::sadc_afe_t o_afe,
   output sadc_pkg::sadc_pwr_t o_pwr_mode
);
   import sadc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection on host strobes and conversion clock
   logic wr_n_ff;
   logic rd_n_ff;
   logic cs_n_ff;
   logic conv_clk_ff;
   logic start;
   logic rd_rise;
   logic cclk_edge;
   logic cclk_rise;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_n_ff <= 1'b1;
         rd_n_ff <= 1'b1;
         cs_n_ff <= 1'b1;
         conv_clk_ff <= 1'b0;
      end else begin
         wr_n_ff <= i_host.wr_n;
         rd_n_ff <= i_host.rd_n;
         cs_n_ff <= i_host.cs_n;
         conv_clk_ff <= i_conv_clk;
      end
   end

   // A second start inside a frame is ignored rather than restarting it
   assign start = wr_n_ff & ~i_host.wr_n & ~i_host.cs_n & o_busy_n;   // R03 R12
   assign rd_rise = ~rd_n_ff & i_host.rd_n & ~cs_n_ff;
   assign cclk_rise = i_conv_clk & ~conv_clk_ff;
   assign cclk_edge = i_conv_clk ^ conv_clk_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencing
   sadc_state_t state_ff;
   sadc_state_t nxt_state;
   logic [SADC_HALF_W-1:0] half_ff;
   logic [SADC_IDX_W-1:0] bit_idx_ff;
   logic [SADC_HALF_W-1:0] bit_len;
   logic decide;
   logic acq_end;
   logic done_ff;

   // Bit 5 gets extra settling; the LSB runs half a cycle longer than a standard bit
   always_comb begin
      unique case (bit_idx_ff)
         SADC_IDX_BIT5: bit_len = SADC_HALVES_BIT5;   // R05
         SADC_IDX_LSB: bit_len = SADC_HALVES_LSB;     // R05
         default: bit_len = SADC_HALVES_STD;          // R05
      endcase
   end

   assign acq_end = (state_ff == SADC_ST_ACQ) & cclk_edge & (half_ff == SADC_ACQ_LAST);   // R06
   assign decide = (state_ff == SADC_ST_CONV) & cclk_edge
      & (half_ff == bit_len - 5'h01);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         SADC_ST_IDLE: begin
            if (start) begin
               nxt_state = SADC_ST_ARMED;
            end
         end
         SADC_ST_ARMED: begin
            if (cclk_rise) begin
               nxt_state = SADC_ST_ACQ;   // R04
            end
         end
         SADC_ST_ACQ: begin
            if (acq_end) begin
               nxt_state = SADC_ST_CONV;
            end
         end
         SADC_ST_CONV: begin
            if (decide && bit_idx_ff == SADC_IDX_LSB) begin
               nxt_state = SADC_ST_IDLE;   // R11
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= SADC_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Half-period counter, restarted at each phase and each bit
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         half_ff <= '0;
      end else if (state_ff == SADC_ST_ARMED || acq_end || decide) begin
         half_ff <= '0;
      end else if (cclk_edge) begin
         half_ff <= half_ff + 5'h01;   // R11
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_idx_ff <= SADC_IDX_MSB;
      end else if (state_ff != SADC_ST_CONV) begin
         bit_idx_ff <= SADC_IDX_MSB;
      end else if (decide && bit_idx_ff != SADC_IDX_LSB) begin
         bit_idx_ff <= bit_idx_ff - 4'h1;   // R05
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= decide & (bit_idx_ff == SADC_IDX_LSB);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Approximation register
   logic [RES_W-1:0] code;

   sadc_sar_core #(
      .RES_W(RES_W)
   ) u_sar (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_load(acq_end),
      .i_decide(decide),
      .i_bit_idx(bit_idx_ff),
      .i_cmp(i_cmp),
      .o_code(code)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Busy and result; result and busy rise on the same edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_busy_n <= 1'b1;
      end else if (start) begin
         o_busy_n <= 1'b0;   // R07
      end else if (done_ff) begin
         o_busy_n <= 1'b1;   // R07 R08
      end
   end

   // Straight binary: the register bits go out unchanged
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result_bus <= RES_W'(SADC_RESULT_RST);
      end else if (done_ff) begin
         o_result_bus <= code;   // R08 R14
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result_bus_oe <= 1'b0;
      end else begin
         o_result_bus_oe <= ~i_host.cs_n & ~i_host.rd_n;   // R13
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Front-end controls
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_afe.chan_sel <= SADC_CHAN_RST;
      end else if (start) begin
         o_afe.chan_sel <= {i_host.chan_addr_bit_hi, i_host.chan_addr_bit_mid,
            i_host.chan_addr_bit_lo};   // R01
      end
   end

   // Switch opens as decisions begin, so later address changes cannot disturb the hold
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_afe.sample_en <= 1'b0;
      end else begin
         o_afe.sample_en <= (nxt_state == SADC_ST_ACQ);   // R06 R09
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_afe.trial_code <= RES_W'(SADC_RESULT_RST);
      end else begin
         o_afe.trial_code <= code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-down; a start outranks a read strobe in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pwr_mode <= SADC_PWR_NONE;
      end else if (start) begin
         o_pwr_mode <= SADC_PWR_NONE;   // R16
      end else if (rd_rise && o_busy_n) begin
         if (i_host.chan_addr_bit_mid) begin
            o_pwr_mode <= SADC_PWR_SLEEP;   // R15
         end else if (i_host.chan_addr_bit_lo) begin
            o_pwr_mode <= SADC_PWR_NAP;     // R15
         end else begin
            o_pwr_mode <= SADC_PWR_NONE;    // R15
         end
      end
   end

endmodule
`default_nettype wire

// file: tb/sadc_front_model.sv
// Purpose: Far-side model: conversion clock source and comparator on the held input.
// Assumes: Conversion clock divided from i_clk, so its edges stay synchronous.
// Notes: Comparator judges the level captured while the sample switch was closed.
`timescale 1ns/100ps
`default_nettype none
module sadc_front_model (
   input wire logic i_clk,
   input wire sadc_pkg::sadc_afe_t i_afe,
   input wire logic [7:0][11:0] i_levels,
   output logic o_conv_clk,
   output logic o_cmp
);
   import sadc_pkg::*;
   logic [1:0] div_ff = 2'h0;
   logic clk_ff = 1'b0;
   logic [11:0] held_ff = 12'h000;
   ////////////////////////////////////////////////////////////////////////////
   // 2.5 MHz, free running like a board oscillator
   always_ff @(posedge i_clk) begin
      div_ff <= div_ff + 2'h1;
      if (div_ff == 2'h3) begin
         clk_ff <= ~clk_ff;
      end
   end
   // Input is frozen once the switch opens, so late level changes cannot leak in
   always_ff @(posedge i_clk) begin
      if (i_afe.sample_en) begin
         held_ff <= i_levels[i_afe.chan_sel];
      end
   end
   assign o_conv_clk = clk_ff;
   assign o_cmp = held_ff >= i_afe.trial_code;
endmodule
`default_nettype wire

// file: tb/sadc_seq_assertions.sv
// Purpose: Port-level checker for the converter sequencer.
// Assumes: Conversion clock edges are at least two system cycles apart.
// Notes: Frame lengths are counted in conversion clock edges seen.
`timescale 1ns/100ps
`default_nettype none
module sadc_seq_assertions #(
   parameter int unsigned RES_W = 12
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire sadc_pkg::sadc_host_t i_host,
   input wire logic i_conv_clk,
   input wire logic i_cmp,
   input wire logic o_busy_n,
   input wire logic [RES_W-1:0] o_result_bus,
   input wire logic o_result_bus_oe,
   input wire sadc_pkg::sadc_afe_t o_afe,
   input wire sadc_pkg::sadc_pwr_t o_pwr_mode
);
   import sadc_pkg::*;
   logic conv_ff, wr_ff, rd_ff, cs_ff, edge_seen, start_hit;
   logic [5:0] acq_ff, dec_ff;
   assign edge_seen = i_conv_clk != conv_ff;
   assign start_hit = wr_ff & ~i_host.wr_n & ~i_host.cs_n & o_busy_n;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conv_ff <= 1'b0;
         wr_ff <= 1'b1;
         rd_ff <= 1'b1;
         cs_ff <= 1'b1;
      end else begin
         conv_ff <= i_conv_clk;
         wr_ff <= i_host.wr_n;
         rd_ff <= i_host.rd_n;
         cs_ff <= i_host.cs_n;
      end
   end
   // Decision count restarts during acquisition, so idle edges never pollute it
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         acq_ff <= 6'h00;
         dec_ff <= 6'h00;
      end else begin
         acq_ff <= o_afe.sample_en ? acq_ff + 6'(edge_seen) : 6'h00;
         dec_ff <= o_afe.sample_en ? 6'h00 : dec_ff + 6'(edge_seen & ~o_busy_n);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_start_busy: assert property (
      start_hit |=> !o_busy_n) else $error("busy did not fall after start");
   a_chan_latch: assert property (
      start_hit |=> o_afe.chan_sel == $past({i_host.chan_addr_bit_hi,
      i_host.chan_addr_bit_mid, i_host.chan_addr_bit_lo})) else $error("wrong channel");
   a_start_wake: assert property (
      start_hit |=> o_pwr_mode == SADC_PWR_NONE) else $error("start left power-down");
   a_acq_length: assert property (
      $fell(o_afe.sample_en) |-> acq_ff == 6'h05) else $error("acquisition length wrong");
   a_dec_length: assert property (
      $rose(o_busy_n) |-> dec_ff == 6'h1b) else $error("decision length wrong");
   a_result_stable: assert property (
      !$rose(o_busy_n) |-> $stable(o_result_bus)) else $error("result moved mid-frame");
   a_bus_enable: assert property (
      o_result_bus_oe == $past(!i_host.cs_n && !i_host.rd_n)) else $error("bus enable wrong");
   // Address is judged as it stood at the read rise; the host may move it right after
   a_pwr_select: assert property (
      !rd_ff && i_host.rd_n && !cs_ff && o_busy_n && !start_hit |=>
      o_pwr_mode == $past({i_host.chan_addr_bit_mid,
      i_host.chan_addr_bit_lo & ~i_host.chan_addr_bit_mid}))
      else $error("power mode wrong");
   a_hold_input: assert property (
      o_afe.sample_en |-> !o_busy_n && $stable(o_afe.chan_sel)) else $error("sampling off-frame");
   a_acq_on_rise: assert property (
      $rose(o_afe.sample_en) |-> $past(edge_seen && i_conv_clk))
      else $error("frame did not open on a conversion clock rise");
endmodule
bind sadc_seq sadc_seq_assertions #(.RES_W(RES_W)) u_chk (
   .i_clk(i_clk),
   .i_rst_n(i_rst_n),
   .i_host(i_host),
   .i_conv_clk(i_conv_clk),
   .i_cmp(i_cmp),
   .o_busy_n(o_busy_n),
   .o_result_bus(o_result_bus),
   .o_result_bus_oe(o_result_bus_oe),
   .o_afe(o_afe),
   .o_pwr_mode(o_pwr_mode)
);
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Host strobes change 1 ns after the rising clock edge.
// Notes: Channel levels are distinct, so a wrong channel shows in the result.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import sadc_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   sadc_host_t host = 6'h38;
   logic conv_clk, cmp, busy_n, oe;
   logic [11:0] result;
   sadc_afe_t afe;
   sadc_pwr_t pwr;
   logic [7:0][11:0] levels = {12'hffe, 12'h5a5, 12'ha5a, 12'h001,
      12'h7ff, 12'h800, 12'hfff, 12'h000};
   int err_count = 0;
   int checked = 0;
   always #25 i_clk = ~i_clk;
   sadc_seq dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_host(host), .i_conv_clk(conv_clk),
      .i_cmp(cmp), .o_busy_n(busy_n), .o_result_bus(result), .o_result_bus_oe(oe),
      .o_afe(afe), .o_pwr_mode(pwr));
   sadc_front_model u_far (.i_clk(i_clk), .i_afe(afe), .i_levels(levels),
      .o_conv_clk(conv_clk), .o_cmp(cmp));
   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Bounded wait: a frame is about 140 cycles here
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy_n !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      if (busy_n !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: busy never returned", $time);
         final_report();
      end
   endtask
   task automatic start(input logic [2:0] ch);
      host.chan_addr_bit_hi = ch[2];
      host.chan_addr_bit_mid = ch[1];
      host.chan_addr_bit_lo = ch[0];
      host.cs_n = 1'b0;
      host.wr_n = 1'b0;
      tick(2);
      check(busy_n, 1'b0);
      check(pwr, SADC_PWR_NONE);
      host.wr_n = 1'b1;
      host.cs_n = 1'b1;
   endtask
   // Convert, read at once, and let the read rise pick the power mode
   task automatic convert_and_read(input logic [2:0] ch);
      start(ch);
      wait_idle();
      check(result, levels[ch]);
      host.cs_n = 1'b0;
      host.rd_n = 1'b0;
      tick(2);
      check(oe, 1'b1);
      host.cs_n = 1'b1;
      host.rd_n = 1'b1;
      tick(2);
      check(oe, 1'b0);
      check(pwr, ch[1] ? 2'b10 : {1'b0, ch[0]});
   endtask
   // A second start and a power-down read during the frame must both be ignored
   task automatic refused_mid_frame();
      start(3'h2);
      tick(6);
      host.chan_addr_bit_lo = 1'b1;
      host.cs_n = 1'b0;
      host.wr_n = 1'b0;
      host.rd_n = 1'b0;
      tick(2);
      host.wr_n = 1'b1;
      host.rd_n = 1'b1;
      host.cs_n = 1'b1;
      tick(2);
      check(pwr, SADC_PWR_NONE);
      wait_idle();
      check(result, levels[2]);
   endtask
   initial begin
      repeat (10) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      tick(2);
      check(busy_n, 1'b1);
      for (int c = 0; c < 8; c++) begin
         convert_and_read(3'(c));
      end
      refused_mid_frame();
      convert_and_read(3'h7);
      final_report();
   end
endmodule
`default_nettype wire
